/* File: rtl/xsd_core.sv */
// Purpose: execution of test-skip, exclusive-or, pointer-arithmetic and table-write words
// Assumes: software issues one instruction word at a time through the register bus
// Notes:   each instruction cycle is four phase ticks from a clock divider
// Contract
// - zero register skips next word, flags untouched
// - skipped two-word instruction costs three cycles
// - operand bit selects access or banked space
// - extended, access, f<=5Fh means indexed pointer2
// - xor literal into accumulator, one cycle
// - xor register, destination bit picks target
// - xor updates only negative and zero
// - extension stays off unless enable bit set
// - enable adds five literal extended instructions
// - extended words touch or use a pointer
// - pointer add/sub has pointer2 return variant
// - return variant adds or subtracts, pops, two cycles
`default_nettype none
module xsd_core
  import xsd_pkg::*;
(
  input  wire logic                       clk_sys,
  input  wire logic                       rstn,
  input  wire logic [xsd_pkg::XSD_AW-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest
);
  import xsd_pkg::*;

  typedef struct packed {
    logic             waitreq;
    logic [31:0]      rdata;
    logic             ext_en;
    logic [15:0]      ir;
    logic [15:0]      nextw;
    logic [7:0]       w;
    logic [4:0]       status;
    logic [3:0]       bank;
    logic [2:0][11:0] ptr;
    logic [20:0]      pc;
    logic [20:0]      tos;
    logic [4:0]       stkptr;
    logic [21:0]      table_pointer;
    logic [7:0]       tbllat;
    logic [11:0]      daddr;
    logic [7:0]       opnd;
    logic [7:0]       res;
    logic             rn;
    logic             rz;
    xsd_state_t       st;
    logic [1:0]       q;
    logic [1:0]       div;
    logic             skip2;
    logic             unhandled;
  } xsd_regs_t;

  xsd_regs_t   s;
  xsd_regs_t   next_s;
  logic [7:0]  dmem [4096];
  logic [7:0]  hold [8];
  logic        mem_we;
  logic [11:0] mem_wa;
  logic [7:0]  mem_wd;
  logic        hold_we;
  logic [11:0] op_addr;
  logic        op_idx;
  logic [7:0]  x_res;
  logic        x_n;
  logic        x_z;
  logic [31:0] rd_val;
  logic [31:0] wv;
  logic        tick;
  logic        wb;
  logic        two;
  logic        op_tst;
  logic        op_xlw;
  logic        op_xwf;
  logic        op_ptr;
  logic        op_ret;
  logic        op_push;
  logic        op_tbl;
  logic [11:0] ptr_new;

  assign avs_readdata    = s.rdata;
  assign avs_waitrequest = s.waitreq;

  xsd_addr u_addr (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .f       (s.ir[7:0]),
    .a       (s.ir[8]),
    .ext_en  (s.ext_en),
    .bank    (s.bank),
    .ptr2    (s.ptr[2]),
    .addr    (op_addr),
    .indexed (op_idx)
  );

  xsd_xor u_xor (
    .opa  (s.w),
    .opb  (op_xlw ? s.ir[7:0] : s.opnd),
    .res  (x_res),
    .neg  (x_n),
    .zero (x_z)
  );

  // decode; extended words only exist while the enable bit is set
  assign op_tst  = s.ir[15:9] == OPC_TSTSKIP;
  assign op_xlw  = s.ir[15:8] == OPC_XORLIT;
  assign op_xwf  = s.ir[15:10] == OPC_XORREG;
  assign op_ptr  = s.ext_en && s.ir[15:9] == OPC_PTRARI;
  assign op_ret  = op_ptr && s.ir[7:6] == PTR_SEL_RET;
  assign op_push = s.ext_en && s.ir[15:8] == OPC_PUSHL;
  assign op_tbl  = s.ir == OPC_TBLWRPI;
  assign two     = xsd_two_word(s.nextw, s.ext_en);
  assign tick    = s.div == XSD_QDIV - 2'h1;
  assign wb      = s.st == XSD_EXEC && s.q == 2'h3 && tick;

  // six-bit literal added to or taken from the chosen pointer
  always_comb begin
    logic [11:0] base;
    base    = op_ret ? s.ptr[2] : s.ptr[s.ir[7:6]];
    ptr_new = s.ir[8] ? base - {6'h00, s.ir[5:0]} : base + {6'h00, s.ir[5:0]};
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    case (avs_address)
      REG_CTRL:   rd_val[CTRL_EXT] = s.ext_en;
      REG_INSTR:  rd_val[15:0] = s.ir;
      REG_NEXTW:  rd_val[15:0] = s.nextw;
      REG_STATUS: rd_val[4:0] = s.status;
      REG_CORE:   rd_val[2:0] = {s.unhandled, s.st == XSD_NOP1 || s.st == XSD_NOP2, s.st != XSD_IDLE};
      REG_WREG:   rd_val[7:0] = s.w;
      REG_BANK:   rd_val[3:0] = s.bank;
      REG_PTR0:   rd_val[11:0] = s.ptr[0];
      REG_PTR1:   rd_val[11:0] = s.ptr[1];
      REG_PTR2:   rd_val[11:0] = s.ptr[2];
      REG_PC:     rd_val[20:0] = s.pc;
      REG_TOS:    rd_val[20:0] = s.tos;
      REG_STKPTR: rd_val[4:0] = s.stkptr;
      REG_TABPTR: rd_val[21:0] = s.table_pointer;
      REG_TBLLAT: rd_val[7:0] = s.tbllat;
      REG_DADDR:  rd_val[11:0] = s.daddr;
      REG_DDATA:  rd_val[7:0] = dmem[s.daddr];
      REG_HOLD:   rd_val[7:0] = hold[s.table_pointer[2:0]];
      default:    rd_val = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_s  = s;
    mem_we  = 1'b0;
    mem_wa  = s.daddr;
    mem_wd  = s.w;
    hold_we = 1'b0;
    wv      = xsd_merge(rd_val, avs_writedata, avs_byteenable);
    // bus: one wait cycle, writes held off while an instruction runs
    next_s.waitreq = 1'b1;
    if ((avs_read || avs_write) && s.waitreq && (avs_read || s.st == XSD_IDLE)) begin
      next_s.waitreq = 1'b0;
      next_s.rdata   = rd_val;
    end
    if (avs_write && !s.waitreq) begin
      case (avs_address)
        REG_CTRL:   next_s.ext_en = wv[CTRL_EXT];
        REG_INSTR: begin
          next_s.ir  = wv[15:0];
          next_s.st  = XSD_EXEC;
          next_s.q   = 2'h0;
          next_s.div = 2'h0;
        end
        REG_NEXTW:  next_s.nextw = wv[15:0];
        REG_STATUS: next_s.status = wv[4:0];
        REG_CORE:   next_s.unhandled = s.unhandled & ~wv[CORE_UNH];
        REG_WREG:   next_s.w = wv[7:0];
        REG_BANK:   next_s.bank = wv[3:0];
        REG_PTR0:   next_s.ptr[0] = wv[11:0];
        REG_PTR1:   next_s.ptr[1] = wv[11:0];
        REG_PTR2:   next_s.ptr[2] = wv[11:0];
        REG_PC:     next_s.pc = wv[20:0];
        REG_TOS:    next_s.tos = wv[20:0];
        REG_STKPTR: next_s.stkptr = wv[4:0];
        REG_TABPTR: next_s.table_pointer = wv[21:0];
        REG_TBLLAT: next_s.tbllat = wv[7:0];
        REG_DADDR:  next_s.daddr = wv[11:0];
        REG_DDATA: begin
          mem_we = 1'b1;
          mem_wd = wv[7:0];
        end
        default: ;
      endcase
    end
    // phase sequencer: decode, operand read, process, write-back
    if (s.st != XSD_IDLE) begin
      next_s.div = tick ? 2'h0 : s.div + 2'h1;
    end
    if (s.st != XSD_IDLE && tick) begin
      next_s.q = s.q + 2'h1;
      if (s.st == XSD_EXEC) begin
        case (s.q)
          2'h1: next_s.opnd = dmem[op_addr];
          2'h2: begin
            next_s.res = x_res;
            next_s.rn  = x_n;
            next_s.rz  = x_z;
          end
          2'h3: begin
            next_s.st = XSD_IDLE;
            next_s.pc = s.pc + PC_STEP;
            if (op_tst) begin
              if (s.opnd == 8'h00) begin
                next_s.st    = XSD_NOP1;
                next_s.skip2 = two;
                next_s.pc    = s.pc + (two ? PC_STEP * 21'h0_0003 : PC_STEP * 21'h0_0002);
              end
            end else if (op_xlw || op_xwf) begin
              if (op_xwf && s.ir[9]) begin
                mem_we = 1'b1;
                mem_wa = op_addr;
                mem_wd = s.res;
              end else begin
                next_s.w = s.res;
              end
              next_s.status[STAT_N] = s.rn;
              next_s.status[STAT_Z] = s.rz;
            end else if (op_ret) begin
              next_s.ptr[2] = ptr_new;
              next_s.pc     = s.tos;
              next_s.stkptr = s.stkptr - 5'h01;
              next_s.st     = XSD_NOP1;
              next_s.skip2  = 1'b0;
            end else if (op_ptr) begin
              next_s.ptr[s.ir[7:6]] = ptr_new;
            end else if (op_push) begin
              mem_we        = 1'b1;
              mem_wa        = s.ptr[2];
              mem_wd        = s.ir[7:0];
              next_s.ptr[2] = s.ptr[2] - 12'h001;
            end else if (op_tbl) begin
              hold_we       = 1'b1;
              next_s.table_pointer = s.table_pointer + 22'h00_0001;
            end else begin
              next_s.unhandled = 1'b1;
            end
          end
          default: ;
        endcase
      end else if (s.q == 2'h3) begin
        // idle cycles only count phases
        next_s.st = (s.st == XSD_NOP1 && s.skip2) ? XSD_NOP2 : XSD_IDLE;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s <= '{waitreq: 1'b1, st: XSD_IDLE, default: '0};
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      dmem[mem_wa] <= mem_wd;
    end
    if (hold_we) begin
      hold[s.table_pointer[2:0]] <= s.tbllat;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  skip_zero_a: assert property (wb && op_tst && s.opnd == 8'h00 |=>
                                s.st == XSD_NOP1 && s.status == $past(s.status))
    else $error("zero test did not skip or touched flags");
  no_skip_a: assert property (wb && op_tst && s.opnd != 8'h00 |=> s.st == XSD_IDLE
                              && s.pc == $past(s.pc) + PC_STEP)
    else $error("nonzero test skipped");
  skip_two_a: assert property (s.st == XSD_NOP1 && s.q == 2'h3 && tick && s.skip2 |=>
                               s.st == XSD_NOP2 ##8 s.st == XSD_IDLE)
    else $error("two word skip not three cycles");
  xor_lit_a: assert property (wb && op_xlw |=> s.w == ($past(s.w) ^ $past(s.ir[7:0])))
    else $error("xor literal result wrong");
  xor_dest_a: assert property (wb && op_xwf |-> mem_we == s.ir[9]
                               ##1 (s.w == ($past(s.ir[9]) ? $past(s.w) : $past(s.res))))
    else $error("xor register destination wrong");
  xor_flags_a: assert property (wb && (op_xlw || op_xwf) |=> s.status[STAT_Z] == ($past(s.res) == 8'h00)
                                && s.status[STAT_N] == $past(s.res[7]) && s.status[3] == $past(s.status[3])
                                && s.status[1:0] == $past(s.status[1:0]))
    else $error("xor status flags wrong");
  ext_off_a: assert property (wb && !s.ext_en |=> s.ptr == $past(s.ptr))
    else $error("pointer changed with extension off");
  ptr_return_a: assert property (wb && op_ret |=> s.pc == $past(s.tos) && s.st == XSD_NOP1
                                 && s.ptr[2] == $past(ptr_new) ##8 s.st == XSD_IDLE)
    else $error("return variant sequence wrong");
  table_inc_a: assert property (wb && op_tbl |-> hold_we ##1 s.table_pointer == $past(s.table_pointer) + 22'h00_0001)
    else $error("table write pointer not advanced");
  nop_quiet_a: assert property (s.st == XSD_NOP1 || s.st == XSD_NOP2 |-> !mem_we && !hold_we)
    else $error("idle cycle wrote data");
endmodule : xsd_core
`default_nettype wire

/* File: rtl/xsd_pkg.sv */
// Purpose: shared constants and types of the xor / skip / extended-set decoder
// Assumes: byte addressed avalon-mm slave, 32-bit data, one word per register
// Notes:   opcode fields are compared against the top bits of the instruction word
`default_nettype none
package xsd_pkg;
  localparam int          XSD_AW      = 8;
  // register byte addresses
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_INSTR   = 8'h04;
  localparam logic [7:0]  REG_NEXTW   = 8'h08;
  localparam logic [7:0]  REG_STATUS  = 8'h0c;
  localparam logic [7:0]  REG_CORE    = 8'h10;
  localparam logic [7:0]  REG_WREG    = 8'h14;
  localparam logic [7:0]  REG_BANK    = 8'h18;
  localparam logic [7:0]  REG_PTR0    = 8'h1c;
  localparam logic [7:0]  REG_PTR1    = 8'h20;
  localparam logic [7:0]  REG_PTR2    = 8'h24;
  localparam logic [7:0]  REG_PC      = 8'h28;
  localparam logic [7:0]  REG_TOS     = 8'h2c;
  localparam logic [7:0]  REG_STKPTR  = 8'h30;
  localparam logic [7:0]  REG_TABPTR  = 8'h34;
  localparam logic [7:0]  REG_TBLLAT  = 8'h38;
  localparam logic [7:0]  REG_DADDR   = 8'h3c;
  localparam logic [7:0]  REG_DDATA   = 8'h40;
  localparam logic [7:0]  REG_HOLD    = 8'h44;
  // field positions
  localparam int          CTRL_EXT    = 0;
  localparam int          CORE_BUSY   = 0;
  localparam int          CORE_SKIP   = 1;
  localparam int          CORE_UNH    = 2;
  localparam int          STAT_Z      = 2;
  localparam int          STAT_N      = 4;
  // opcodes
  localparam logic [6:0]  OPC_TSTSKIP = 7'h33;
  localparam logic [7:0]  OPC_XORLIT  = 8'h0a;
  localparam logic [5:0]  OPC_XORREG  = 6'h06;
  localparam logic [6:0]  OPC_PTRARI  = 7'h74;
  localparam logic [7:0]  OPC_PUSHL   = 8'hea;
  localparam logic [15:0] OPC_TBLWRPI = 16'h000d;
  localparam logic [1:0]  PTR_SEL_RET = 2'h3;
  localparam logic [7:0]  IDX_MAX     = 8'h5f;
  localparam logic [3:0]  ACC_HI_BANK = 4'hf;
  // timing: phase tick every XSD_QDIV clocks, four phases per instruction cycle
  localparam logic [1:0]  XSD_QDIV    = 2'h2;
  localparam logic [20:0] PC_STEP     = 21'h0_0002;

  typedef enum logic [1:0] {
    XSD_IDLE = 2'b00,
    XSD_EXEC = 2'b01,
    XSD_NOP1 = 2'b10,
    XSD_NOP2 = 2'b11
  } xsd_state_t;

  // instructions that occupy two program words
  function automatic logic xsd_two_word(input logic [15:0] wd, input logic ext);
    xsd_two_word = (wd[15:12] == 4'hc) || (wd[15:8] >= 8'hec && wd[15:8] <= 8'hef)
                   || (ext && wd[15:8] == 8'heb);
  endfunction : xsd_two_word

  function automatic logic [31:0] xsd_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    xsd_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        xsd_merge[8*i +: 8] = wd[8*i +: 8];
      end
    end
  endfunction : xsd_merge
endpackage : xsd_pkg
`default_nettype wire

/* File: rtl/xsd_xor.sv */
// Purpose: exclusive-or unit with negative and zero flags
// Assumes: purely combinational, result sampled by the caller
// Notes:   none
`default_nettype none
module xsd_xor (
  input  wire logic [7:0] opa,
  input  wire logic [7:0] opb,
  output logic      [7:0] res,
  output logic            neg,
  output logic            zero
);
  assign res  = opa ^ opb;
  assign neg  = res[7];
  assign zero = (res == 8'h00);
endmodule : xsd_xor
`default_nettype wire

/* File: rtl/xsd_addr.sv */
// Purpose: data address resolution for byte-oriented operands
// Assumes: 12-bit data space, 4-bit bank select
// Notes:   clock and reset only feed the checks
`default_nettype none
module xsd_addr
  import xsd_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [7:0]  f,
  input  wire logic        a,
  input  wire logic        ext_en,
  input  wire logic [3:0]  bank,
  input  wire logic [11:0] ptr2,
  output logic      [11:0] addr,
  output logic             indexed
);
  assign indexed = ext_en && !a && (f <= IDX_MAX);
  always_comb begin
    if (indexed) begin
      addr = ptr2 + {4'h0, f};
    end else if (a) begin
      addr = {bank, f};
    end else begin
      addr = {(f[7] ? ACC_HI_BANK : 4'h0), f};
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  bank_select_a: assert property (a |-> addr == {bank, f})
    else $error("banked operand address wrong");
  access_bank_a: assert property (!a && !(ext_en && f <= IDX_MAX) |-> addr[7:0] == f
                                  && addr[11:8] == (f[7] ? ACC_HI_BANK : 4'h0))
    else $error("access bank address wrong");
  literal_index_a: assert property (!a && ext_en && f <= IDX_MAX |-> indexed
                                    && addr == ptr2 + {4'h0, f})
    else $error("indexed offset address wrong");
endmodule : xsd_addr
`default_nettype wire

/* File: verif/xsd_avm.sv */
// Purpose: avalon-mm master model driving the decoder's register bus
// Assumes: slave answers by dropping waitrequest for one cycle
// Notes:   a released bus shows inverted values, not the last request
`default_nettype none
module xsd_avm (
  input  wire logic        clk_sys,
  output logic      [7:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
  end
  // raise after an edge, hold until waitrequest is sampled low, then release
  task automatic xfer(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                      output logic [31:0] rd, output logic ok);
    ok = 1'b0;
    rd = 32'h0000_0000;
    @(posedge clk_sys);
    avs_address <= ad;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    for (int n = 0; n < 200 && !ok; n++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) begin
        ok = 1'b1;
        rd = avs_readdata;
      end
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~ad;
    avs_writedata <= ~wd;
  endtask : xfer
endmodule : xsd_avm
`default_nettype wire

/* File: verif/tb_top.sv */
// Purpose: self-checking bench of the xor / skip / extended-set decoder
// Assumes: instructions issued one at a time through the register bus
// Notes:   cycle counts are measured by polling the busy bit
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import xsd_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  xsd_avm i_mst (.clk_sys(clk_sys), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  xsd_core i_dut (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] v);
    logic ok;
    i_mst.xfer(w, ad, wd, v, ok);
    if (!ok) begin
      fail_count++;
      $display("MISMATCH bus_answer expected 1 seen 0");
      tally_and_finish();
    end
  endtask : acc
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    logic [31:0] v;
    acc(1'b1, ad, wd, v);
  endtask : wr
  task automatic cr(input string nm, input logic [7:0] ad, input logic [31:0] exp);
    logic [31:0] v;
    acc(1'b0, ad, 32'h0000_0000, v);
    chk(nm, exp, v);
  endtask : cr
  task automatic mset(input logic [11:0] ad, input logic [7:0] d);
    wr(REG_DADDR, {20'h0_0000, ad});
    wr(REG_DDATA, {24'h00_0000, d});
  endtask : mset
  task automatic mchk(input string nm, input logic [11:0] ad, input logic [7:0] d);
    wr(REG_DADDR, {20'h0_0000, ad});
    cr(nm, REG_DDATA, {24'h00_0000, d});
  endtask : mchk
  // issue one word and measure clocks until busy drops
  task automatic run(input logic [15:0] wd, input int n);
    logic [31:0] v;
    int t0;
    logic idle;
    idle = 1'b0;
    wr(REG_INSTR, {16'h0000, wd});
    t0 = cyc;
    for (int i = 0; i < 30 && !idle; i++) begin
      acc(1'b0, REG_CORE, 32'h0000_0000, v);
      idle = (v[CORE_BUSY] === 1'b0);
    end
    chk("busy_drop", 32'h0000_0001, {31'h0, idle && (cyc - t0 >= n - 1) && (cyc - t0 <= n + 4)});
    if (!idle) begin
      tally_and_finish();
    end
  endtask : run
  task automatic t_base();
    cr("ctrl_rst", REG_CTRL, 32'h0000_0000);
    cr("wreg_rst", REG_WREG, 32'h0000_0000);
    wr(8'h4c, 32'h1234_5678);
    cr("unmapped", 8'h4c, 32'h0000_0000);
    $display("test t_base done");
  endtask : t_base
  task automatic t_xorlit();
    wr(REG_WREG, 32'h0000_00b5);
    wr(REG_STATUS, 32'h0000_000b);
    run(16'h0aaf, 8);
    cr("w_xorlit", REG_WREG, 32'h0000_001a);
    cr("st_nz0", REG_STATUS, 32'h0000_000b);
    run(16'h0a1a, 8);
    cr("st_z", REG_STATUS, 32'h0000_000f);
    run(16'h0a80, 8);
    cr("w_neg", REG_WREG, 32'h0000_0080);
    cr("st_n", REG_STATUS, 32'h0000_001b);
    $display("test t_xorlit done");
  endtask : t_xorlit
  task automatic t_xorreg();
    wr(REG_BANK, 32'h0000_0003);
    mset(12'h320, 8'haf);
    wr(REG_WREG, 32'h0000_00b5);
    run(16'h1b20, 8);
    mchk("banked_dest", 12'h320, 8'h1a);
    cr("w_kept", REG_WREG, 32'h0000_00b5);
    mset(12'hf90, 8'h0f);
    wr(REG_STATUS, 32'h0000_0000);
    run(16'h1890, 8);
    cr("w_dest", REG_WREG, 32'h0000_00ba);
    mchk("access_hi", 12'hf90, 8'h0f);
    cr("st_xorreg", REG_STATUS, 32'h0000_0010);
    $display("test t_xorreg done");
  endtask : t_xorreg
  task automatic t_index();
    logic [7:0]  f [4] = '{8'h5f, 8'h5f, 8'h60, 8'h00};
    logic        e [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
    logic [11:0] ea [4] = '{12'h05f, 12'h25f, 12'h060, 12'h200};
    wr(REG_PTR2, 32'h0000_0200);
    wr(REG_WREG, 32'h0000_00ff);
    for (int i = 0; i < 4; i++) begin
      wr(REG_CTRL, {31'h0, e[i]});
      mset(ea[i], 8'h3c);
      run({8'h1a, f[i]}, 8);
      mchk("idx_addr", ea[i], 8'hc3);
    end
    $display("test t_index done");
  endtask : t_index
  task automatic t_skip();
    logic [7:0]  m [3] = '{8'h00, 8'h01, 8'h00};
    logic [15:0] nw [3] = '{16'h0000, 16'h0000, 16'hc000};
    int          dp [3] = '{4, 2, 6};
    int          cy [3] = '{16, 8, 24};
    wr(REG_CTRL, 32'h0000_0000);
    wr(REG_STATUS, 32'h0000_001f);
    wr(REG_WREG, 32'h0000_0077);
    for (int i = 0; i < 3; i++) begin
      wr(REG_PC, 32'h0000_0100);
      mset(12'h030, m[i]);
      wr(REG_NEXTW, {16'h0000, nw[i]});
      run(16'h6630, cy[i]);
      cr("pc_skip", REG_PC, 32'h0000_0100 + dp[i]);
      cr("st_skip", REG_STATUS, 32'h0000_001f);
      cr("w_skip", REG_WREG, 32'h0000_0077);
    end
    $display("test t_skip done");
  endtask : t_skip
  task automatic t_ext();
    wr(REG_CTRL, 32'h0000_0001);
    wr(REG_PTR2, 32'h0000_03ff);
    run(16'he8a3, 8);
    cr("ptr2_add", REG_PTR2, 32'h0000_0422);
    wr(REG_PTR1, 32'h0000_0100);
    run(16'he945, 8);
    cr("ptr1_sub", REG_PTR1, 32'h0000_00fb);
    wr(REG_PTR2, 32'h0000_03ff);
    wr(REG_PC, 32'h0000_0100);
    wr(REG_TOS, 32'h0000_02ae);
    wr(REG_STKPTR, 32'h0000_0005);
    run(16'he8e3, 16);
    cr("ptr2_ret", REG_PTR2, 32'h0000_0422);
    cr("pc_ret", REG_PC, 32'h0000_02ae);
    cr("stk_ret", REG_STKPTR, 32'h0000_0004);
    run(16'he9c1, 16);
    cr("ptr2_subret", REG_PTR2, 32'h0000_0421);
    cr("stk_subret", REG_STKPTR, 32'h0000_0003);
    run(16'hea55, 8);
    mchk("push_mem", 12'h421, 8'h55);
    cr("ptr2_push", REG_PTR2, 32'h0000_0420);
    wr(REG_CTRL, 32'h0000_0000);
    run(16'he8a3, 8);
    cr("ptr2_off", REG_PTR2, 32'h0000_0420);
    cr("unhandled", REG_CORE, 32'h0000_0004);
    wr(REG_CORE, 32'h0000_0004);
    cr("unh_clear", REG_CORE, 32'h0000_0000);
    $display("test t_ext done");
  endtask : t_ext
  task automatic t_tbl();
    wr(REG_TABPTR, 32'h0000_a356);
    wr(REG_TBLLAT, 32'h0000_0055);
    run(16'h000d, 8);
    cr("table_pointer_inc", REG_TABPTR, 32'h0000_a357);
    cr("tbllat_kept", REG_TBLLAT, 32'h0000_0055);
    wr(REG_TABPTR, 32'h0000_a356);
    cr("hold_byte", REG_HOLD, 32'h0000_0055);
    $display("test t_tbl done");
  endtask : t_tbl
  initial begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    t_base();
    t_xorlit();
    t_xorreg();
    t_index();
    t_skip();
    t_ext();
    t_tbl();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
